// >>> rtl/svwr_pkg.sv
// Function
// - Reset is pulled low through an open-drain stage while the primary supply is reported low.
// - Once the primary supply is reported good again, reset stays low 200 ms more, then releases.
// - At power up reset is low, and it stays low 200 ms after the supply is reported stable.
// - With the watchdog enabled, no start edge within the selected timeout asserts reset.
// - A falling data edge while the clock is high restarts the watchdog; the host must send one.
// - Three preset watchdog timeouts exist, and the choice sits in storage that survives power.
// - The second-supply fail pin is low while the monitor is below its trip level, high above.
// - The second-supply fail pin has no power-up delay and follows its comparator directly.
// - The second-supply fail path is independent of the primary reset path.
// - With the protect pin high and the protect enable bit set, control writes are refused.
// - Two device select inputs are compared with the received address, four devices per bus.
// - The watchdog timeout comes from two stored control bits.
// - Reset from low supply or watchdog aborts a transfer and blocks new ones while it lasts.
// - A stored write already running finishes under reset; none may start under reset.
package svwr_pkg;

  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;

  localparam int unsigned POR_MS = 200;
  localparam int unsigned POR_CYCLES_DEF = POR_MS * CYC_PER_MS;
  localparam int unsigned WD_SHORT_MS = 100;
  localparam int unsigned WD_MID_MS = 500;
  localparam int unsigned WD_LONG_MS = 1000;
  localparam int unsigned WD_SHORT_CYCLES_DEF = WD_SHORT_MS * CYC_PER_MS;
  localparam int unsigned WD_MID_CYCLES_DEF = WD_MID_MS * CYC_PER_MS;
  localparam int unsigned WD_LONG_CYCLES_DEF = WD_LONG_MS * CYC_PER_MS;
  localparam int unsigned NV_WRITE_MS = 5;
  localparam int unsigned NV_WRITE_CYCLES_DEF = NV_WRITE_MS * CYC_PER_MS;

  localparam int unsigned CNT_W = 32;

  // Control byte layout
  localparam int unsigned CTRL_W = 8;
  localparam int unsigned PROT_BIT = 7;
  localparam int unsigned WD_HI_BIT = 6;
  localparam int unsigned WD_LO_BIT = 5;
  localparam logic [7:0] CTRL_FACTORY = 8'h00;

  // Watchdog period selections
  localparam logic [1:0] WD_SEL_LONG = 2'h0;
  localparam logic [1:0] WD_SEL_MID = 2'h1;
  localparam logic [1:0] WD_SEL_SHORT = 2'h2;
  localparam logic [1:0] WD_SEL_OFF = 2'h3;

  // Slave address byte: type code, select high, select low, direction
  localparam int unsigned TYPE_W = 5;
  localparam logic [4:0] DEV_TYPE_DEF = 5'h16; // arbitrary value
  localparam logic [3:0] ADDR_BITS = 4'h8;

  // Synchroniser lane order
  localparam int unsigned SYNC_W = 7;
  localparam int unsigned LN_SUPPLY = 0;
  localparam int unsigned LN_V2 = 1;
  localparam int unsigned LN_SCL = 2;
  localparam int unsigned LN_SDA = 3;
  localparam int unsigned LN_WP = 4;
  localparam int unsigned LN_SEL_LO = 5;
  localparam int unsigned LN_SEL_HI = 6;

  typedef enum logic [1:0] {
    ST_LOW = 2'b00,
    ST_DELAY = 2'b01,
    ST_RUN = 2'b10
  } svwr_state_t;

endpackage

// >>> rtl/svwr_sync.sv
`timescale 1ns/1ns
module svwr_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] dout_reg;
  logic [WIDTH-1:0] dout_next;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("svwr_sync width must be at least one");
    end
  endgenerate

  always_comb begin
    meta_next = din;
    dout_next = meta_reg;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta_reg <= '0;
      dout_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      dout_reg <= dout_next;
    end
  end

  assign dout = dout_reg;

endmodule

// >>> rtl/svwr_top.sv
`timescale 1ns/1ns
module svwr_top #(
  parameter int unsigned POR_CYCLES = svwr_pkg::POR_CYCLES_DEF,
  parameter int unsigned WD_SHORT_CYCLES = svwr_pkg::WD_SHORT_CYCLES_DEF,
  parameter int unsigned WD_MID_CYCLES = svwr_pkg::WD_MID_CYCLES_DEF,
  parameter int unsigned WD_LONG_CYCLES = svwr_pkg::WD_LONG_CYCLES_DEF,
  parameter int unsigned NV_WRITE_CYCLES = svwr_pkg::NV_WRITE_CYCLES_DEF,
  parameter logic [svwr_pkg::TYPE_W-1:0] DEV_TYPE = svwr_pkg::DEV_TYPE_DEF
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic supply_ok_in,
  input wire logic second_supply_monitor_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic protect_pin_in,
  input wire logic device_select_low,
  input wire logic device_select_high,
  input wire logic ctrl_wr_req,
  input wire logic [svwr_pkg::CTRL_W-1:0] ctrl_wr_data,
  output logic sys_reset_out,
  output logic sys_reset_oe,
  output logic second_supply_fail_out,
  output logic second_supply_fail_oe,
  output logic ctrl_wr_refused,
  output logic nv_busy,
  output logic [svwr_pkg::CTRL_W-1:0] ctrl_value,
  output logic addr_match,
  output logic addr_read,
  output logic xfer_abort,
  output logic bus_enable
);
  import svwr_pkg::*;

  generate
    if (POR_CYCLES < 1 || WD_SHORT_CYCLES < 1 || WD_MID_CYCLES < 1 ||
        WD_LONG_CYCLES < 1 || NV_WRITE_CYCLES < 1) begin : g_bad_count
      $error("svwr_top counts must be at least one cycle");
    end
  endgenerate

  logic [SYNC_W-1:0] pins_s;
  logic supply_ok_s;
  logic v2_ok_s;
  logic scl_s;
  logic sda_s;
  logic wp_s;

  // Every pin, straps included, is crossed before use
  svwr_sync #(.WIDTH(SYNC_W)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .din({device_select_high, device_select_low, protect_pin_in, sda_in, scl_in,
          second_supply_monitor_in, supply_ok_in}),
    .dout(pins_s)
  );

  assign supply_ok_s = pins_s[LN_SUPPLY];
  assign v2_ok_s = pins_s[LN_V2];
  assign scl_s = pins_s[LN_SCL];
  assign sda_s = pins_s[LN_SDA];
  assign wp_s = pins_s[LN_WP];

  function automatic logic [CNT_W-1:0] wd_limit(input logic [1:0] sel);
    case (sel)
      WD_SEL_LONG: wd_limit = CNT_W'(WD_LONG_CYCLES);
      WD_SEL_MID: wd_limit = CNT_W'(WD_MID_CYCLES);
      WD_SEL_SHORT: wd_limit = CNT_W'(WD_SHORT_CYCLES);
      default: wd_limit = '0;
    endcase
  endfunction

  svwr_state_t state_reg, state_next;
  logic [CNT_W-1:0] dly_cnt_reg, dly_cnt_next;
  logic [CNT_W-1:0] wd_cnt_reg, wd_cnt_next;
  logic scl_prev_reg, scl_prev_next;
  logic sda_prev_reg, sda_prev_next;
  logic in_xfer_reg, in_xfer_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [7:0] shift_reg, shift_next;
  logic match_reg, match_next;
  logic read_reg, read_next;
  logic abort_reg, abort_next;
  logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
  logic [CTRL_W-1:0] pend_reg, pend_next;
  logic [CNT_W-1:0] nv_cnt_reg, nv_cnt_next;
  logic busy_reg, busy_next;
  logic refused_reg, refused_next;

  logic start_edge;
  logic stop_edge;
  logic scl_rise;
  logic reset_active;
  logic [1:0] wd_sel;
  logic wd_en;
  logic wd_expire;
  logic protect_block;

  assign start_edge = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
  assign stop_edge = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;
  assign scl_rise = scl_s && !scl_prev_reg;
  assign reset_active = (state_reg != ST_RUN);
  assign wd_sel = {ctrl_reg[WD_HI_BIT], ctrl_reg[WD_LO_BIT]};
  assign wd_en = (wd_sel != WD_SEL_OFF);
  assign wd_expire = wd_en && (wd_cnt_reg == wd_limit(wd_sel) - CNT_W'(1));
  assign protect_block = wp_s && ctrl_reg[PROT_BIT];

  always_comb begin
    state_next = state_reg;
    dly_cnt_next = '0;
    wd_cnt_next = '0;
    case (state_reg)
      ST_LOW: begin
        if (supply_ok_s) begin
          state_next = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (!supply_ok_s) begin
          state_next = ST_LOW;
        end else if (dly_cnt_reg == CNT_W'(POR_CYCLES - 1)) begin
          state_next = ST_RUN;
        end else begin
          dly_cnt_next = dly_cnt_reg + CNT_W'(1);
        end
      end
      ST_RUN: begin
        if (!supply_ok_s) begin
          state_next = ST_LOW;
        end else if (start_edge || !wd_en) begin
          wd_cnt_next = '0;
        end else if (wd_expire) begin
          // Watchdog reset is held for the same delay as a supply recovery
          state_next = ST_DELAY;
        end else begin
          wd_cnt_next = wd_cnt_reg + CNT_W'(1);
        end
      end
      default: state_next = ST_LOW;
    endcase
  end

  always_comb begin
    scl_prev_next = scl_s;
    sda_prev_next = sda_s;
    in_xfer_next = in_xfer_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next = shift_reg;
    match_next = 1'b0;
    read_next = read_reg;
    abort_next = 1'b0;
    if (reset_active) begin
      in_xfer_next = 1'b0;
      bit_cnt_next = '0;
      abort_next = in_xfer_reg;
    end else if (start_edge) begin
      in_xfer_next = 1'b1;
      bit_cnt_next = '0;
    end else if (stop_edge) begin
      in_xfer_next = 1'b0;
    end else if (in_xfer_reg && scl_rise && bit_cnt_reg < ADDR_BITS) begin
      shift_next = {shift_reg[6:0], sda_s};
      bit_cnt_next = bit_cnt_reg + 4'h1;
      if (bit_cnt_reg == ADDR_BITS - 4'h1) begin
        match_next = (shift_next[7:1] == {DEV_TYPE, pins_s[LN_SEL_HI],
                                          pins_s[LN_SEL_LO]});
        read_next = shift_next[0];
      end
    end
  end

  always_comb begin
    ctrl_next = ctrl_reg;
    pend_next = pend_reg;
    nv_cnt_next = nv_cnt_reg;
    busy_next = busy_reg;
    refused_next = 1'b0;
    if (busy_reg) begin
      // Runs to its end whatever the reset state
      if (nv_cnt_reg == CNT_W'(NV_WRITE_CYCLES - 1)) begin
        busy_next = 1'b0;
        ctrl_next = pend_reg;
        nv_cnt_next = '0;
      end else begin
        nv_cnt_next = nv_cnt_reg + CNT_W'(1);
      end
    end else if (ctrl_wr_req) begin
      if (protect_block || reset_active) begin
        refused_next = 1'b1;
      end else begin
        busy_next = 1'b1;
        pend_next = ctrl_wr_data;
        nv_cnt_next = '0;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= ST_LOW;
      dly_cnt_reg <= '0;
      wd_cnt_reg <= '0;
      scl_prev_reg <= 1'b0;
      sda_prev_reg <= 1'b0;
      in_xfer_reg <= 1'b0;
      bit_cnt_reg <= '0;
      shift_reg <= '0;
      match_reg <= 1'b0;
      read_reg <= 1'b0;
      abort_reg <= 1'b0;
      ctrl_reg <= CTRL_FACTORY;
      pend_reg <= CTRL_FACTORY;
      nv_cnt_reg <= '0;
      busy_reg <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      dly_cnt_reg <= dly_cnt_next;
      wd_cnt_reg <= wd_cnt_next;
      scl_prev_reg <= scl_prev_next;
      sda_prev_reg <= sda_prev_next;
      in_xfer_reg <= in_xfer_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= shift_next;
      match_reg <= match_next;
      read_reg <= read_next;
      abort_reg <= abort_next;
      ctrl_reg <= ctrl_next;
      pend_reg <= pend_next;
      nv_cnt_reg <= nv_cnt_next;
      busy_reg <= busy_next;
      refused_reg <= refused_next;
    end
  end

  assign sys_reset_out = 1'b0;
  assign sys_reset_oe = reset_active;
  assign second_supply_fail_out = 1'b0;
  // Straight from the synchroniser, no delay and no primary gating
  assign second_supply_fail_oe = !v2_ok_s;
  assign ctrl_wr_refused = refused_reg;
  assign nv_busy = busy_reg;
  assign ctrl_value = ctrl_reg;
  assign addr_match = match_reg;
  assign addr_read = read_reg;
  assign xfer_abort = abort_reg;
  assign bus_enable = !reset_active;

  sequence s_protected_req;
    ctrl_wr_req && !busy_reg && protect_block;
  endsequence

  sequence s_refusal;
    ctrl_wr_refused && !nv_busy;
  endsequence

  property p_refuse;
    @(posedge clk_sys) disable iff (!rst_n) s_protected_req |=> s_refusal;
  endproperty

  supply_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !supply_ok_s |=> sys_reset_oe && state_reg == ST_LOW)
    else $error("reset not asserted on low supply");

  release_delay_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_reg == ST_RUN && $past(state_reg) != ST_RUN)
    |-> $past(dly_cnt_reg) == CNT_W'(POR_CYCLES - 1) && $past(supply_ok_s))
    else $error("reset released before delay ended");

  power_up_a: assert property (@(posedge clk_sys)
    $rose(rst_n) |-> sys_reset_oe ##1 sys_reset_oe)
    else $error("reset not held at power up");

  wd_timeout_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_reg == ST_RUN && wd_expire && supply_ok_s && !start_edge)
    |=> sys_reset_oe && dly_cnt_reg == '0)
    else $error("watchdog expiry did not assert reset");

  wd_restart_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state_reg == ST_RUN && start_edge && supply_ok_s) |=> wd_cnt_reg == '0
    ##1 (wd_cnt_reg <= CNT_W'(1)))
    else $error("start edge did not restart watchdog");

  wd_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wd_sel == WD_SEL_OFF)[*2] |-> wd_cnt_reg == '0 && !wd_expire)
    else $error("disabled watchdog is counting");

  // Pin to output in exactly the two synchroniser stages, nothing more
  second_fail_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(rst_n) && $past(rst_n, 2)
    |-> second_supply_fail_oe == !$past(second_supply_monitor_in, 2))
    else $error("second fail output not following comparator");

  protect_refuse_a: assert property (p_refuse)
    else $error("protected control write was not refused");

  reset_abort_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reset_active && in_xfer_reg) |=> xfer_abort && !in_xfer_reg && !addr_match)
    else $error("transfer not aborted under reset");

  nv_guard_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ctrl_wr_req && !busy_reg && reset_active) |=> !nv_busy && ctrl_wr_refused)
    else $error("stored write started under reset");

endmodule

// >>> sim/svwr_host.sv
`timescale 1ns/1ns
module svwr_host (
  input wire logic go,
  input wire logic [7:0] byte_in,
  output logic scl,
  output logic sda,
  output logic busy
);
  // Bus idles high on its pull-ups, the clock only runs within a frame
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    busy = 1'b0;
  end
  always @(posedge go) begin
    busy = 1'b1;
    // Odd offset keeps the start edge off the sampling clock edge
    #61 sda = 1'b0;
    #60 scl = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sda = byte_in[i];
      #62 scl = 1'b1;
      #63 scl = 1'b0;
    end
    sda = 1'b0;
    #62 scl = 1'b1;
    #62 sda = 1'b1;
    busy = 1'b0;
  end
endmodule

// >>> sim/svwr_top_tb_top.sv
`timescale 1ns/1ns
module svwr_top_tb_top;
  import svwr_pkg::*;
  localparam int POR = 40;
  localparam int WDS = 400;
  localparam int WDM = 600;
  localparam int WDL = 800;
  localparam int NVW = 5;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic supply_ok_in = 1'b0;
  logic mon = 1'b0;
  logic wp = 1'b0;
  logic sel_lo = 1'b0;
  logic sel_hi = 1'b0;
  logic req = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic h_go = 1'b0;
  logic [7:0] h_byte = 8'h00;
  logic scl, sda, h_busy;
  logic rst_out, rst_oe, v2_out, v2_oe, refused, nv_busy, addr_match, addr_read, abort, bus_en;
  logic [7:0] ctrl_value;
  logic [7:0] exp_ctrl = 8'h00;
  logic su1, su2, sc1, sc2, sc3, sd1, sd2, sd3, v1, v2;
  int mst, mcnt, wcnt;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int n_match = 0;
  int n_abort = 0;

  always #2 clk_sys = ~clk_sys;

  svwr_top #(.POR_CYCLES(POR), .WD_SHORT_CYCLES(WDS), .WD_MID_CYCLES(WDM),
    .WD_LONG_CYCLES(WDL), .NV_WRITE_CYCLES(NVW)) u_svwr_top (
    .clk_sys(clk_sys), .rst_n(rst_n), .supply_ok_in(supply_ok_in),
    .second_supply_monitor_in(mon), .scl_in(scl), .sda_in(sda), .protect_pin_in(wp),
    .device_select_low(sel_lo), .device_select_high(sel_hi), .ctrl_wr_req(req),
    .ctrl_wr_data(wdata), .sys_reset_out(rst_out), .sys_reset_oe(rst_oe),
    .second_supply_fail_out(v2_out), .second_supply_fail_oe(v2_oe),
    .ctrl_wr_refused(refused), .nv_busy(nv_busy), .ctrl_value(ctrl_value),
    .addr_match(addr_match), .addr_read(addr_read), .xfer_abort(abort), .bus_enable(bus_en));

  svwr_host u_svwr_host (.go(h_go), .byte_in(h_byte), .scl(scl), .sda(sda), .busy(h_busy));

  function automatic int wd_lim();
    case (exp_ctrl[6:5])
      2'h0: return WDL;
      2'h1: return WDM;
      2'h2: return WDS;
      default: return 0;
    endcase
  endfunction

  // Reference: 0 held low, 1 counting the release delay, 2 running
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    v1 <= rst_n & mon;
    v2 <= rst_n & v1;
    if (addr_match === 1'b1) n_match <= n_match + 1;
    if (abort === 1'b1) n_abort <= n_abort + 1;
    if (cyc % 37 == 0) mon <= 1'($urandom_range(0, 1));
    if (!rst_n) begin
      {su1, su2, sc1, sc2, sc3, sd1, sd2, sd3} <= 8'h00;
      mst <= 0;
      mcnt <= 0;
      wcnt <= 0;
    end else begin
      {su2, su1} <= {su1, supply_ok_in};
      {sc3, sc2, sc1} <= {sc2, sc1, scl};
      {sd3, sd2, sd1} <= {sd2, sd1, sda};
      case (mst)
        0: if (su2) begin mst <= 1; mcnt <= 0; end
        1: if (!su2) mst <= 0;
          else if (mcnt == POR - 1) begin mst <= 2; wcnt <= 0; end
          else mcnt <= mcnt + 1;
        default: if (!su2) mst <= 0;
          // A disabled watchdog holds its count at zero
          else if ((sc2 && sc3 && sd3 && !sd2) || wd_lim() == 0) wcnt <= 0;
          else if (wd_lim() != 0 && wcnt == wd_lim() - 1) begin mst <= 1; mcnt <= 0; end
          else wcnt <= wcnt + 1;
      endcase
    end
    if (cyc == 30000) begin
      bad_count++;
      wrap_up();
    end
  end

  always @(negedge clk_sys) begin
    chk_bit(rst_oe, mst != 2);
    chk_bit(bus_en, mst == 2);
    chk_bit(rst_out, 1'b0);
    chk_bit(v2_oe, ~v2);
    chk_bit(v2_out, 1'b0);
  end

  task automatic chk_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic wr_ctrl(input logic [7:0] d, input logic exp_ref);
    int k;
    @(posedge clk_sys);
    req <= 1'b1;
    wdata <= d;
    @(posedge clk_sys);
    req <= 1'b0;
    @(negedge clk_sys);
    chk_bit(refused, exp_ref);
    chk_bit(nv_busy, !exp_ref);
    if (!exp_ref) begin
      k = 0;
      while (nv_busy === 1'b1 && k < 100) begin
        @(negedge clk_sys);
        k++;
      end
      chk_byte(8'(k), 8'(NVW));
      chk_byte(ctrl_value, d);
      exp_ctrl = d;
    end
  endtask

  task automatic send(input logic [7:0] b);
    int k;
    @(posedge clk_sys);
    h_byte <= b;
    h_go <= 1'b1;
    @(posedge clk_sys);
    h_go <= 1'b0;
    k = 0;
    while (h_busy !== 1'b0 && k < 1000) begin
      @(posedge clk_sys);
      k++;
    end
    // Pin synchronisers lag the wire
    repeat (8) @(posedge clk_sys);
  endtask

  task automatic wrap_up();
    if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    int m0;
    logic rd;
    void'($urandom(9173));
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    supply_ok_in <= 1'b1;
    repeat (POR + 10) @(posedge clk_sys);
    wr_ctrl(8'he0, 1'b0);
    wp <= 1'b1;
    repeat (3) @(posedge clk_sys);
    wr_ctrl(8'h60, 1'b1);
    wp <= 1'b0;
    repeat (3) @(posedge clk_sys);
    wr_ctrl(8'h60, 1'b0);
    wp <= 1'b1;
    repeat (3) @(posedge clk_sys);
    wr_ctrl(8'h60, 1'b0);
    wp <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      {sel_hi, sel_lo} <= 2'(s);
      rd = 1'($urandom_range(0, 1));
      repeat (3) @(posedge clk_sys);
      m0 = n_match;
      send({DEV_TYPE_DEF, 2'(s), rd});
      chk_byte(8'(n_match - m0), 8'h01);
      chk_bit(addr_read, rd);
      send({DEV_TYPE_DEF, ~sel_hi, sel_lo, rd});
      chk_byte(8'(n_match - m0), 8'h01);
    end
    // Two frames outlast the shortest interval, so restarts must hold reset off
    for (int sel = 0; sel < 3; sel++) begin
      wr_ctrl({1'b0, 2'(sel), 5'($urandom)}, 1'b0);
      send(8'($urandom));
      send(8'($urandom));
      repeat (WDL + POR + 20) @(posedge clk_sys);
    end
    wr_ctrl(8'h60, 1'b0);
    repeat (WDL + 100) @(posedge clk_sys);
    m0 = n_abort;
    fork
      send(8'h00);
      begin
        repeat (80) @(posedge clk_sys);
        fork
          wr_ctrl(8'h40, 1'b0);
          begin
            repeat (2) @(posedge clk_sys);
            supply_ok_in <= 1'b0;
          end
        join
      end
    join
    chk_byte(8'(n_abort - m0), 8'h01);
    wr_ctrl(8'h20, 1'b1);
    m0 = n_match;
    send({DEV_TYPE_DEF, sel_hi, sel_lo, 1'b0});
    chk_byte(8'(n_match - m0), 8'h00);
    supply_ok_in <= 1'b1;
    repeat (POR + 20) @(posedge clk_sys);
    chk_byte(ctrl_value, exp_ctrl);
    wrap_up();
  end
endmodule
